/* File: rtl/rtc_ext_ctrl.sv */
`include "rtc_ext_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module rtc_ext_ctrl #(
   parameter int XRAM_DEPTH = `XRAM_DEPTH_DEFAULT,
   parameter int UIP_LEAD_CYCLES = `UIP_LEAD_NS / `CLK_PERIOD_NS,
   parameter int unsigned POTO_CYCLES =
      int'((64'(`POTO_S) * 64'd1000000000) / 64'(`CLK_PERIOD_NS))
) (
   input wire logic I_CLOCK,
   input wire logic I_RESET,
   input wire logic [7:0] i_MUXED_ADDR_DATA_BUS,
   input wire logic i_ALE,
   input wire logic i_RD_N,
   input wire logic i_WR_N,
   input wire logic i_CHIP_SELECT_N,
   input wire logic i_BANK_SELECT_BIT,
   input wire logic i_KICK_INPUT_N,
   input wire logic i_USER_RAM_CLEAR_N,
   input wire logic i_POWER_GOOD,
   input wire logic i_AUX_BATTERY_OK,
   input wire logic i_OSC_32K,
   input wire logic i_ALARM_MATCH,
   input wire logic i_OSC_RUNNING,
   input wire logic [2:0] i_DIVIDER_CTRL,
   input wire logic i_OTHER_IRQ,
   input wire logic i_SQUARE_WAVE_PROGRAMMED,
   input wire logic i_UPDATE_DUE,
   input wire logic i_UPDATE_DONE,
   output logic [7:0] o_MUXED_ADDR_DATA_BUS,
   output logic o_MUXED_ADDR_DATA_BUS_OE,
   output logic o_POWER_ON_REQUEST_N,
   output logic o_POWER_ON_REQUEST_N_OE,
   output logic o_IRQ_N,
   output logic o_IRQ_N_OE,
   output logic o_SQUARE_WAVE_OUT,
   output logic o_URAM_WE,
   output logic [6:0] o_URAM_ADDR,
   output logic [7:0] o_URAM_WDATA,
   output logic o_UPDATE_START
);
   localparam int XA_W = $clog2(XRAM_DEPTH);
   localparam int REC_CYCLES = (`REC_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam logic [6:0] URAM_LAST = 7'(`USER_RAM_BYTES - 1);

   rtc_ext_pkg::state_t s;
   rtc_ext_pkg::state_t next_s;
   logic [7:0] xram [XRAM_DEPTH];
   logic [16:0] synced;
   logic [7:0] ad;
   logic ale, rd_n, wr_n, cs_n, kick_n, clr_n, pg, aux_ok, osc;
   logic sel, locked, rd_rise, wr_rise, wr_acc, rd_acc, data_acc;
   logic alarm_rise, kick_fall, clr_fall, pg_rise, pg_fall, run_ok;
   logic wake_en, kick_en, pend_en, new_en_event;
   logic [7:0] rd_mux;
   logic [XA_W-1:0] xidx;

   pin_sync #(
      .WIDTH(17),
      .RESET_VALUE(`SYNC_RESET)
   ) u_pin_sync (
      .i_clock(I_CLOCK),
      .i_reset(I_RESET),
      .i_async({i_MUXED_ADDR_DATA_BUS, i_ALE, i_RD_N, i_WR_N, i_CHIP_SELECT_N,
                i_KICK_INPUT_N, i_USER_RAM_CLEAR_N, i_POWER_GOOD, i_AUX_BATTERY_OK,
                i_OSC_32K}),
      .o_sync(synced)
   );

   assign {ad, ale, rd_n, wr_n, cs_n, kick_n, clr_n, pg, aux_ok, osc} = synced;
   assign xidx = s.xaddr[XA_W-1:0];

   always_comb begin
      wake_en = s.wake_flag & s.feature[`BIT_WAKE_IRQ_ENABLE];
      kick_en = s.kick_flag & s.feature[`BIT_KICK_ENABLE];
      pend_en = wake_en | kick_en;
      locked = (s.lock_cnt != 8'h00) || (s.clr_state != rtc_ext_pkg::CLR_IDLE);
      sel = i_BANK_SELECT_BIT && !cs_n && !locked &&
            (s.addr == `OFS_EXT_STATUS_CONTROL || s.addr == `OFS_EXT_FEATURE_ENABLE ||
             s.addr == `OFS_XRAM_ADDR_LOW || s.addr == `OFS_XRAM_ADDR_HIGH ||
             s.addr == `OFS_XRAM_DATA_PORT);
      rd_rise = rd_n && !s.rd_q;
      wr_rise = wr_n && !s.wr_q;
      rd_acc = rd_rise && sel;
      wr_acc = wr_rise && sel;
      data_acc = (rd_acc || wr_acc) && s.addr == `OFS_XRAM_DATA_PORT;
      alarm_rise = i_ALARM_MATCH && !s.alarm_q;
      kick_fall = !kick_n && s.kick_q;
      clr_fall = !clr_n && s.clr_q;
      pg_rise = pg && !s.pg_q;
      pg_fall = !pg && s.pg_q;
      // Divider field 01X means the countdown chain runs
      run_ok = i_OSC_RUNNING && i_DIVIDER_CTRL[2:1] == `DIVIDER_RUN_CODE &&
               s.feature[`BIT_AUX_SUPPLY_ENABLE];
      new_en_event = (alarm_rise && s.feature[`BIT_WAKE_IRQ_ENABLE]) ||
                     (kick_fall && s.feature[`BIT_KICK_ENABLE]);
      unique case (s.addr)
         `OFS_EXT_STATUS_CONTROL:
            rd_mux = {aux_ok, s.update_in_progress, s.burst_enable, 1'b0,
                      s.power_off_bit, s.ram_clear_flag, s.wake_flag, s.kick_flag};
         `OFS_EXT_FEATURE_ENABLE: rd_mux = s.feature;
         `OFS_XRAM_ADDR_LOW: rd_mux = s.xaddr[7:0];
         `OFS_XRAM_ADDR_HIGH: rd_mux = {3'h0, s.xaddr[12:8]};
         `OFS_XRAM_DATA_PORT: rd_mux = xram[xidx];
         default: rd_mux = 8'h00;
      endcase
   end

   always_comb begin
      next_s = s;
      next_s.ale_q = ale;
      next_s.rd_q = rd_n;
      next_s.wr_q = wr_n;
      next_s.kick_q = kick_n;
      next_s.clr_q = clr_n;
      next_s.pg_q = pg;
      next_s.alarm_q = i_ALARM_MATCH;
      next_s.update_start = 1'b0;
      next_s.uram_we = 1'b0;
      if (!ale && s.ale_q) begin
         next_s.addr = ad;
      end
      if (wr_acc) begin
         unique case (s.addr)
            `OFS_EXT_STATUS_CONTROL: begin
               next_s.burst_enable = ad[`BIT_BURST_ENABLE];
               next_s.power_off_bit = ad[`BIT_POWER_OFF];
               next_s.ram_clear_flag = ad[`BIT_RAM_CLEAR_FLAG];
               next_s.wake_flag = ad[`BIT_WAKE_FLAG];
               next_s.kick_flag = ad[`BIT_KICK_FLAG];
            end
            `OFS_EXT_FEATURE_ENABLE: next_s.feature = ad;
            `OFS_XRAM_ADDR_LOW: next_s.xaddr[7:0] = ad;
            `OFS_XRAM_ADDR_HIGH: next_s.xaddr[12:8] = ad[4:0];
            default: next_s.feature = s.feature;
         endcase
      end
      // Address stands still unless burst is on
      if (data_acc && s.burst_enable) begin
         next_s.xaddr = s.xaddr + 13'h0001;
      end
      // Hardware sets win over a same-cycle software clear
      if (alarm_rise) begin
         next_s.wake_flag = 1'b1;
      end
      if (kick_fall) begin
         next_s.kick_flag = 1'b1;
      end
      if (pg_rise) begin
         next_s.feature[`BIT_OSC_OUTPUT_ENABLE] = 1'b1;
      end
      // Battery side reacts to fresh events only, so a power fail
      // with stale flags does not bounce the supply back on.
      if ((pg && pend_en) || (!pg && run_ok && new_en_event)) begin
         next_s.power_off_bit = 1'b0;
      end
      if (pg_fall && !s.feature[`BIT_POWERFAIL_OUTPUT_SELECT]) begin
         next_s.power_off_bit = 1'b1;
      end
      if (!pg && run_ok && new_en_event) begin
         next_s.poto_run = 1'b1;
         next_s.poto_cnt = 27'h0000000;
      end else if (pg) begin
         next_s.poto_run = 1'b0;
      end else if (s.poto_run) begin
         next_s.poto_cnt = s.poto_cnt + 27'h0000001;
         if (s.poto_cnt >= 27'(POTO_CYCLES - 1)) begin
            next_s.poto_run = 1'b0;
            next_s.power_off_bit = 1'b1;
         end
      end
      if (clr_fall) begin
         next_s.lock_cnt = 8'(REC_CYCLES);
      end else if (s.lock_cnt != 8'h00) begin
         next_s.lock_cnt = s.lock_cnt - 8'h01;
      end
      unique case (s.clr_state)
         rtc_ext_pkg::CLR_IDLE: begin
            if (clr_fall && s.feature[`BIT_RAM_CLEAR_ENABLE]) begin
               next_s.clr_state = rtc_ext_pkg::CLR_RUN;
               next_s.clr_idx = 7'h00;
            end
         end
         rtc_ext_pkg::CLR_RUN: begin
            next_s.uram_we = 1'b1;
            next_s.uram_addr = s.clr_idx;
            next_s.uram_wdata = 8'hFF;
            next_s.clr_idx = s.clr_idx + 7'h01;
            if (s.clr_idx == URAM_LAST) begin
               next_s.clr_state = rtc_ext_pkg::CLR_DONE;
            end
         end
         rtc_ext_pkg::CLR_DONE: begin
            next_s.ram_clear_flag = 1'b1;
            next_s.clr_state = rtc_ext_pkg::CLR_IDLE;
         end
         default: next_s.clr_state = rtc_ext_pkg::CLR_IDLE;
      endcase
      if (i_UPDATE_DUE && !s.update_in_progress) begin
         next_s.update_in_progress = 1'b1;
         next_s.uip_cnt = 13'(UIP_LEAD_CYCLES);
      end else if (s.uip_cnt != 13'h0000) begin
         next_s.uip_cnt = s.uip_cnt - 13'h0001;
         next_s.update_start = (s.uip_cnt == 13'h0001);
      end else if (i_UPDATE_DONE) begin
         next_s.update_in_progress = 1'b0;
      end
      next_s.ad_out = rd_mux;
      next_s.ad_oe = !rd_n && sel;
      next_s.power_req_oe = !s.power_off_bit;
      next_s.irq_oe = pg && (pend_en || i_OTHER_IRQ ||
                      (s.ram_clear_flag && s.feature[`BIT_RAM_CLEAR_IRQ_ENABLE]));
      // Oscillator passes a 3-flop path (2 sync stages plus the output register); jitter of one cycle is accepted
      next_s.square_wave = s.feature[`BIT_OSC_OUTPUT_ENABLE] ? osc :
                           i_SQUARE_WAVE_PROGRAMMED;
   end

   always_ff @(posedge I_CLOCK) begin
      if (I_RESET) begin
         s <= '0;
         s.rd_q <= 1'b1;
         s.wr_q <= 1'b1;
         s.kick_q <= 1'b1;
         s.clr_q <= 1'b1;
         s.power_off_bit <= `POWER_OFF_RESET;
         s.feature <= `FEATURE_ENABLE_RESET;
         s.clr_state <= rtc_ext_pkg::CLR_IDLE;
      end else begin
         s <= next_s;
      end
   end

   always_ff @(posedge I_CLOCK) begin
      if (wr_acc && s.addr == `OFS_XRAM_DATA_PORT) begin
         xram[xidx] <= ad;
      end
   end

   assign o_MUXED_ADDR_DATA_BUS = s.ad_out;
   assign o_MUXED_ADDR_DATA_BUS_OE = s.ad_oe;
   assign o_POWER_ON_REQUEST_N = s.uram_wdata[7] & 1'b0;
   assign o_POWER_ON_REQUEST_N_OE = s.power_req_oe;
   assign o_IRQ_N = s.uram_wdata[7] & 1'b0;
   assign o_IRQ_N_OE = s.irq_oe;
   assign o_SQUARE_WAVE_OUT = s.square_wave;
   assign o_URAM_WE = s.uram_we;
   assign o_URAM_ADDR = s.uram_addr;
   assign o_URAM_WDATA = s.uram_wdata;
   assign o_UPDATE_START = s.update_start;

   default clocking cb @(posedge I_CLOCK);
   endclocking
   default disable iff (I_RESET);

   property p_off_cleared;
      pg && pend_en |=> !s.power_off_bit ##1 o_POWER_ON_REQUEST_N_OE;
   endproperty
   a_off_cleared: assert property (p_off_cleared) else $error("off bit stuck");

   property p_off_releases;
      s.power_off_bit && !pend_en |=> !o_POWER_ON_REQUEST_N_OE;
   endproperty
   a_off_releases: assert property (p_off_releases) else $error("power request driven");

   // Interrupt follows an enabled pending flag while main power is up
   property p_irq_on_event;
      pg && pend_en |=> o_IRQ_N_OE;
   endproperty
   a_irq_on_event: assert property (p_irq_on_event) else $error("irq not raised");

   property p_irq_masked;
      !pend_en && !i_OTHER_IRQ &&
         !(s.ram_clear_flag && s.feature[`BIT_RAM_CLEAR_IRQ_ENABLE]) |=> !o_IRQ_N_OE;
   endproperty
   a_irq_masked: assert property (p_irq_masked) else $error("irq unmasked");

   property p_powerfail_release;
      pg_fall && !s.feature[`BIT_POWERFAIL_OUTPUT_SELECT] && !(run_ok && new_en_event) |=>
         s.power_off_bit;
   endproperty
   a_powerfail_release: assert property (p_powerfail_release) else $error("power fail output");

   property p_clear_runs;
      s.clr_state == rtc_ext_pkg::CLR_RUN && s.clr_idx == 7'h00 |->
         ##114 s.clr_state == rtc_ext_pkg::CLR_DONE ##1 s.ram_clear_flag;
   endproperty
   a_clear_runs: assert property (p_clear_runs) else $error("clear length");

   property p_clear_disabled;
      clr_fall && !s.feature[`BIT_RAM_CLEAR_ENABLE] && s.clr_state == rtc_ext_pkg::CLR_IDLE |=>
         s.clr_state == rtc_ext_pkg::CLR_IDLE;
   endproperty
   a_clear_disabled: assert property (p_clear_disabled) else $error("clear ran");

   property p_lockout;
      clr_fall |=> (!wr_acc && !rd_acc)[*8];
   endproperty
   a_lockout: assert property (p_lockout) else $error("access in lockout");

   property p_no_burst;
      data_acc && !s.burst_enable |=> $stable(s.xaddr);
   endproperty
   a_no_burst: assert property (p_no_burst) else $error("address moved");

   property p_burst;
      data_acc && s.burst_enable |=> s.xaddr == $past(s.xaddr) + 13'h0001;
   endproperty
   a_burst: assert property (p_burst) else $error("burst step");

   property p_osc_on;
      pg_rise |=> s.feature[`BIT_OSC_OUTPUT_ENABLE];
   endproperty
   a_osc_on: assert property (p_osc_on) else $error("osc enable");

   c_burst_read: cover property (rd_acc && s.burst_enable && s.addr == 8'h53);
   c_ram_clear: cover property (s.clr_state == rtc_ext_pkg::CLR_DONE);
   c_kick_wake: cover property (!pg && run_ok && new_en_event);
   c_timeout: cover property (s.poto_run && s.poto_cnt >= 27'(POTO_CYCLES - 1));
endmodule
`default_nettype wire

/* File: rtl/rtc_ext_regs.svh */
`ifndef RTC_EXT_REGS_SVH
`define RTC_EXT_REGS_SVH

// Register offsets on the multiplexed bus, extended bank
`define OFS_EXT_STATUS_CONTROL 8'h4A
`define OFS_EXT_FEATURE_ENABLE 8'h4B
`define OFS_XRAM_ADDR_LOW 8'h50
`define OFS_XRAM_ADDR_HIGH 8'h51
`define OFS_XRAM_DATA_PORT 8'h53

// ext_status_control fields
`define BIT_AUX_BATTERY_OK 7
`define BIT_UPDATE_IN_PROGRESS 6
`define BIT_BURST_ENABLE 5
`define BIT_POWER_OFF 3
`define BIT_RAM_CLEAR_FLAG 2
`define BIT_WAKE_FLAG 1
`define BIT_KICK_FLAG 0

// ext_feature_enable fields
`define BIT_AUX_SUPPLY_ENABLE 7
`define BIT_OSC_OUTPUT_ENABLE 6
`define BIT_CRYSTAL_SELECT 5
`define BIT_RAM_CLEAR_ENABLE 4
`define BIT_POWERFAIL_OUTPUT_SELECT 3
`define BIT_RAM_CLEAR_IRQ_ENABLE 2
`define BIT_WAKE_IRQ_ENABLE 1
`define BIT_KICK_ENABLE 0

// Reset values and divider run code
`define FEATURE_ENABLE_RESET 8'h00
`define POWER_OFF_RESET 1'b0
`define SYNC_RESET 17'h000F8
`define DIVIDER_RUN_CODE 2'h1

// Sizes and timing
`define USER_RAM_BYTES 114
`define XRAM_DEPTH_DEFAULT 8192
`define CLK_PERIOD_NS 20
`define UIP_LEAD_NS 122000
`define POTO_S 2
`define REC_TIME_NS 1000

`endif

/* File: rtl/rtc_ext_pkg.sv */
package rtc_ext_pkg;

   typedef enum logic [2:0] {
      CLR_IDLE = 3'b001,
      CLR_RUN  = 3'b010,
      CLR_DONE = 3'b100
   } clr_state_t;

   typedef struct packed {
      logic [7:0] addr;
      logic ale_q;
      logic rd_q;
      logic wr_q;
      logic kick_q;
      logic clr_q;
      logic pg_q;
      logic alarm_q;
      logic burst_enable;
      logic power_off_bit;
      logic ram_clear_flag;
      logic wake_flag;
      logic kick_flag;
      logic update_in_progress;
      logic [7:0] feature;
      logic [12:0] xaddr;
      logic [7:0] lock_cnt;
      clr_state_t clr_state;
      logic [6:0] clr_idx;
      logic poto_run;
      logic [26:0] poto_cnt;
      logic [12:0] uip_cnt;
      logic [7:0] ad_out;
      logic ad_oe;
      logic power_req_oe;
      logic irq_oe;
      logic square_wave;
      logic uram_we;
      logic [6:0] uram_addr;
      logic [7:0] uram_wdata;
      logic update_start;
   } state_t;

endpackage

/* File: rtl/pin_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   input wire logic i_clock,
   input wire logic i_reset,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } sync_t;

   sync_t s;
   sync_t next_s;

   // Only the second stage is visible outside
   always_comb begin
      next_s.meta = i_async;
      next_s.stable = s.meta;
   end

   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         s.meta <= RESET_VALUE;
         s.stable <= RESET_VALUE;
      end else begin
         s <= next_s;
      end
   end

   assign o_sync = s.stable;
endmodule
`default_nettype wire

/* File: dv/rtc_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module rtc_host_model (
   input wire logic i_clock,
   input wire logic [7:0] i_bus,
   input wire logic i_bus_oe,
   output logic [7:0] o_ad,
   output logic o_ale,
   output logic o_rd_n,
   output logic o_wr_n,
   output logic o_cs_n,
   output logic o_bank
);
   logic drv = 1'b0;
   logic [7:0] val = 8'h00;
   logic [7:0] idle = 8'h5A;
   logic bank_en = 1'b1;
   initial begin
      o_ale = 1'b0;
      o_rd_n = 1'b1;
      o_wr_n = 1'b1;
      o_cs_n = 1'b1;
      o_bank = 1'b1;
   end
   // Released bus toggles, so stale data never passes for an answer
   always @(posedge i_clock) idle <= ~idle;
   assign o_ad = (i_bus_oe === 1'b1) ? i_bus : (drv ? val : idle);
   task automatic access(input logic [7:0] a, input logic rd, input logic [7:0] wd,
         output logic [7:0] q, output logic ok);
      int n;
      ok = 1'b0;
      q = 8'h00;
      @(posedge i_clock);
      #1;
      o_bank = bank_en;
      o_cs_n = 1'b0;
      drv = 1'b1;
      val = a;
      o_ale = 1'b1;
      @(posedge i_clock);
      #1;
      o_ale = 1'b0;
      repeat (5) @(posedge i_clock);
      #1;
      if (rd) begin
         drv = 1'b0;
         o_rd_n = 1'b0;
         for (n = 0; n < 12; n++) begin
            @(posedge i_clock);
            if (i_bus_oe === 1'b1 && !ok) begin
               ok = 1'b1;
               q = i_bus;
            end
         end
      end else begin
         val = wd;
         o_wr_n = 1'b0;
         repeat (6) @(posedge i_clock);
      end
      #1;
      o_rd_n = 1'b1;
      o_wr_n = 1'b1;
      // Data held past the strobe rise for the input synchronisers
      repeat (3) @(posedge i_clock);
      #1;
      drv = 1'b0;
      repeat (5) @(posedge i_clock);
      #1;
      o_cs_n = 1'b1;
   endtask
endmodule
`default_nettype wire

/* File: dv/power_ramclear_xram_ctrl_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; \
$display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module power_ramclear_xram_ctrl_tb;
   logic I_CLOCK = 1'b0;
   logic I_RESET = 1'b1;
   logic kick_n = 1'b1, clr_n = 1'b1, pg = 1'b0, aux = 1'b1, osc = 1'b0;
   logic alarm = 1'b0, other = 1'b0, due = 1'b0, done = 1'b0, run = 1'b1;
   logic sq_prog = 1'b1;
   logic [2:0] div = 3'b010;
   logic [7:0] ad, q, bus, wdat;
   logic ale, rd_n, wr_n, cs_n, bank, bus_oe, power_req, power_req_oe, irq, irq_oe;
   logic sq_wave, we, start, ok;
   logic [6:0] waddr;
   int failures = 0, compares = 0, we_cnt = 0, n;
   always #10 I_CLOCK = ~I_CLOCK;
   always #200 osc = ~osc;
   rtc_ext_ctrl #(.UIP_LEAD_CYCLES(20), .POTO_CYCLES(200)) rtc_ext_ctrl_inst (
      .I_CLOCK(I_CLOCK), .I_RESET(I_RESET), .i_MUXED_ADDR_DATA_BUS(ad), .i_ALE(ale),
      .i_RD_N(rd_n), .i_WR_N(wr_n), .i_CHIP_SELECT_N(cs_n), .i_BANK_SELECT_BIT(bank),
      .i_KICK_INPUT_N(kick_n), .i_USER_RAM_CLEAR_N(clr_n), .i_POWER_GOOD(pg),
      .i_AUX_BATTERY_OK(aux), .i_OSC_32K(osc), .i_ALARM_MATCH(alarm), .i_OSC_RUNNING(run),
      .i_DIVIDER_CTRL(div), .i_OTHER_IRQ(other), .i_SQUARE_WAVE_PROGRAMMED(sq_prog),
      .i_UPDATE_DUE(due), .i_UPDATE_DONE(done), .o_MUXED_ADDR_DATA_BUS(bus),
      .o_MUXED_ADDR_DATA_BUS_OE(bus_oe), .o_POWER_ON_REQUEST_N(power_req),
      .o_POWER_ON_REQUEST_N_OE(power_req_oe), .o_IRQ_N(irq), .o_IRQ_N_OE(irq_oe),
      .o_SQUARE_WAVE_OUT(sq_wave), .o_URAM_WE(we), .o_URAM_ADDR(waddr), .o_URAM_WDATA(wdat),
      .o_UPDATE_START(start));
   rtc_host_model rtc_host_model_inst (.i_clock(I_CLOCK), .i_bus(bus), .i_bus_oe(bus_oe),
      .o_ad(ad), .o_ale(ale), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_cs_n(cs_n), .o_bank(bank));
   always @(posedge I_CLOCK) begin
      if (we === 1'b1) begin
         `CHK(waddr, we_cnt[6:0])
         `CHK(wdat, 8'hFF)
         we_cnt <= we_cnt + 1;
      end
   end
   task automatic cyc(input int k);
      repeat (k) @(posedge I_CLOCK);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      rtc_host_model_inst.access(a, 1'b0, d, q, ok);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      rtc_host_model_inst.access(a, 1'b1, 8'h00, q, ok);
      `CHK(ok, 1'b1)
      `CHK(q, e)
   endtask
   task automatic rno(input logic [7:0] a);
      rtc_host_model_inst.access(a, 1'b1, 8'h00, q, ok);
      `CHK(ok, 1'b0)
   endtask
   task automatic kick(input int k);
      kick_n = 1'b0;
      cyc(k);
      kick_n = 1'b1;
      cyc(6);
   endtask
   task automatic wake;
      alarm = 1'b1;
      cyc(4);
      alarm = 1'b0;
      cyc(4);
   endtask
   task automatic test_end(input string s);
      $display("test %s done: compares %0d failures %0d", s, compares, failures);
   endtask
   task automatic final_report;
      $display("totals: compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge I_CLOCK);
      failures++;
      final_report;
   end
   initial begin
      cyc(10);
      I_RESET = 1'b0;
      cyc(5);
      `CHK(power_req_oe, 1'b1)
      `CHK(power_req, 1'b0)
      rchk(8'h4B, 8'h00);
      rchk(8'h4A, 8'h80);
      aux = 1'b0;
      cyc(5);
      rchk(8'h4A, 8'h00);
      aux = 1'b1;
      pg = 1'b1;
      cyc(6);
      rchk(8'h4B, 8'h40);
      // Oscillator edges never meet a rising clock edge, so the sync delay is fixed
      @(posedge osc);
      cyc(5);
      `CHK(sq_wave, 1'b1)
      @(negedge osc);
      cyc(5);
      `CHK(sq_wave, 1'b0)
      wr(8'h4A, 8'h10);
      rchk(8'h4A, 8'h80);
      rtc_host_model_inst.bank_en = 1'b0;
      wr(8'h4B, 8'hFF);
      rtc_host_model_inst.bank_en = 1'b1;
      rchk(8'h4B, 8'h40);
      rno(8'h52);
      test_end("registers");
      wr(8'h4B, 8'h02);
      `CHK(sq_wave, 1'b1)
      sq_prog = 1'b0;
      cyc(2);
      `CHK(sq_wave, 1'b0)
      wr(8'h4A, 8'h08);
      `CHK(power_req_oe, 1'b0)
      wake();
      `CHK(irq_oe, 1'b1)
      `CHK(irq, 1'b0)
      `CHK(power_req_oe, 1'b1)
      rchk(8'h4A, 8'h82);
      other = 1'b1;
      wr(8'h4A, 8'h00);
      `CHK(irq_oe, 1'b1)
      other = 1'b0;
      cyc(3);
      `CHK(irq_oe, 1'b0)
      wr(8'h4B, 8'h01);
      kick(100);
      `CHK(irq_oe, 1'b1)
      rchk(8'h4A, 8'h81);
      wr(8'h4A, 8'h00);
      `CHK(irq_oe, 1'b0)
      wr(8'h4B, 8'h00);
      wr(8'h4A, 8'h08);
      kick(100);
      wake();
      rchk(8'h4A, 8'h8B);
      `CHK(irq_oe, 1'b0)
      `CHK(power_req_oe, 1'b0)
      wr(8'h4A, 8'h02);
      rchk(8'h4A, 8'h82);
      wr(8'h4A, 8'h00);
      test_end("wake and kick");
      wr(8'h4B, 8'h10);
      clr_n = 1'b0;
      cyc(10);
      rno(8'h4A);
      cyc(200);
      clr_n = 1'b1;
      `CHK(we_cnt, 114)
      rchk(8'h4A, 8'h84);
      `CHK(irq_oe, 1'b0)
      wr(8'h4B, 8'h14);
      `CHK(irq_oe, 1'b1)
      wr(8'h4A, 8'h00);
      `CHK(irq_oe, 1'b0)
      wr(8'h4A, 8'h04);
      `CHK(irq_oe, 1'b1)
      wr(8'h4A, 8'h00);
      wr(8'h4B, 8'h00);
      we_cnt = 0;
      clr_n = 1'b0;
      cyc(250);
      clr_n = 1'b1;
      `CHK(we_cnt, 0)
      rchk(8'h4A, 8'h80);
      test_end("ram clear");
      wr(8'h50, 8'h34);
      wr(8'h51, 8'h12);
      wr(8'h53, 8'hA5);
      rchk(8'h53, 8'hA5);
      rchk(8'h53, 8'hA5);
      rchk(8'h50, 8'h34);
      rchk(8'h51, 8'h12);
      wr(8'h4A, 8'h20);
      wr(8'h50, 8'hFC);
      wr(8'h51, 8'h1F);
      for (n = 0; n < 3; n++) wr(8'h53, 8'h10 + 8'(n));
      rchk(8'h50, 8'hFF);
      wr(8'h50, 8'hFC);
      for (n = 0; n < 3; n++) rchk(8'h53, 8'h10 + 8'(n));
      wr(8'h4A, 8'h00);
      test_end("extended ram");
      due = 1'b1;
      cyc(1);
      due = 1'b0;
      n = 0;
      while (start !== 1'b1 && n < 100) begin
         @(posedge I_CLOCK);
         n++;
      end
      `CHK(n >= 18 && n <= 22, 1'b1)
      cyc(1);
      rchk(8'h4A, 8'hC0);
      done = 1'b1;
      cyc(1);
      done = 1'b0;
      cyc(4);
      rchk(8'h4A, 8'h80);
      test_end("update");
      wr(8'h4B, 8'h08);
      pg = 1'b0;
      cyc(6);
      `CHK(power_req_oe, 1'b1)
      pg = 1'b1;
      cyc(6);
      wr(8'h4B, 8'h00);
      pg = 1'b0;
      cyc(6);
      `CHK(power_req_oe, 1'b0)
      pg = 1'b1;
      cyc(6);
      wr(8'h4B, 8'h81);
      wr(8'h4A, 8'h08);
      pg = 1'b0;
      cyc(6);
      kick_n = 1'b0;
      cyc(10);
      `CHK(power_req_oe, 1'b1)
      cyc(90);
      kick_n = 1'b1;
      cyc(130);
      `CHK(power_req_oe, 1'b0)
      div = 3'b000;
      kick(100);
      `CHK(power_req_oe, 1'b0)
      div = 3'b010;
      pg = 1'b1;
      cyc(6);
      test_end("power control");
      final_report;
   end
endmodule
`default_nettype wire
